// ---- spi_flags_pkg.sv ----
// Constants shared by the serial target block and its testbench.
// Assumes a 32-bit frame: R/W bit, 6-bit address, 24 data bits, parity.
package spi_flags_pkg;
    // ==========================================================
    // Frame layout
    localparam int FRAME_BITS = 32;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 24;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CNT_FULL = 6'h20;
    localparam logic [CNT_W-1:0] CNT_ADDR_DONE = 6'h06;
    localparam logic [CNT_W-1:0] CNT_MAX = 6'h3f;
    localparam int RW_POS = 31;
    localparam int ADDR_MSB = 30;
    localparam int ADDR_LSB = 25;
    localparam int DATA_MSB = 24;
    localparam int DATA_LSB = 1;
    localparam int FLAG_W = 7;

    // ==========================================================
    // Register map
    localparam logic [ADDR_W-1:0] ADDR_DEVICE_ID = 6'h01;
    localparam logic [ADDR_W-1:0] ADDR_EVENT_STAT = 6'h02;
    localparam logic [ADDR_W-1:0] ADDR_CFG_FIRST = 6'h1a;
    localparam logic [ADDR_W-1:0] ADDR_CFG_LAST = 6'h32;
    localparam int CFG_COUNT = 25;
    localparam logic [ADDR_W-1:0] ADDR_TEST_FIRST = 6'h3a;
    localparam logic [ADDR_W-1:0] ADDR_TEST_LAST = 6'h3f;
    localparam int TEST_COUNT = 6;
    localparam logic [DATA_W-1:0] CFG_RESET = 24'h000000;
    // Arbitrary neutral identity value
    localparam logic [DATA_W-1:0] DEVICE_ID_DEFAULT = 24'h000011;
    localparam logic [DATA_W-1:0] TEST_DEFAULT = 24'h000000;

    // ==========================================================
    // Event status bit positions
    localparam int STAT_W = 14;
    localparam int EV_RESET = 0;
    localparam int EV_LENGTH = 1;
    localparam int EV_PARITY = 2;
    localparam int EV_SWITCH = 3;
    localparam int EV_THERM_SD = 4;
    localparam int EV_THERM_WARN = 5;
    localparam int EV_OVER_V = 6;
    localparam int EV_UNDER_V = 7;
    localparam int EV_CHECKSUM = 8;
    localparam int EV_SUPPLY_A = 9;
    localparam int EV_SUPPLY_B = 10;
    localparam int EV_WETTING = 11;
    localparam int EV_CONVERTER = 12;
    localparam int EV_INTEGRITY = 13;
    localparam logic [STAT_W-1:0] EVENT_STAT_RESET = 14'h0001;
endpackage : spi_flags_pkg

// ---- pin_sync3.sv ----
// Three-stage synchroniser for a level arriving from outside the clock domain.
// Assumes the input is a plain level; the output only moves once stages two and three agree.
`timescale 1ns/1ps
module pin_sync3 #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_async,
    output logic o_level
);
    logic meta_reg;
    logic mid_reg;
    logic last_reg;
    logic level_reg;

    // ==========================================================
    // Stages; the first stage feeds only the second
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_reg <= RESET_VAL;
            mid_reg <= RESET_VAL;
            last_reg <= RESET_VAL;
        end else begin
            meta_reg <= i_async;
            mid_reg <= meta_reg;
            last_reg <= mid_reg;
        end
    end

    // ==========================================================
    // Accepted level
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            level_reg <= RESET_VAL;
        end else if (mid_reg == last_reg) begin
            level_reg <= last_reg;
        end
    end

    assign o_level = level_reg;
endmodule : pin_sync3

// ---- spi_frame_target.sv ----
// Serial target: frame decode, response shifting, event status and config registers.
// Assumes the host keeps the serial clock low around chip select edges and leaves
// a few system clocks between frames so the commit can finish, and waits about
// six system clocks after select falls so the flag snapshot is frozen first.
// Operation
// - Six address bits follow the R/W bit and select the register.
// - Bits 24 to 1 of a read frame are ignored.
// - Bit 0 of each frame is parity, both directions.
// - Read answer: status flags, then addressed register, then parity.
// - Test registers read back contents; unmapped addresses read all zeros.
// - Writes to non-writable addresses change nothing.
// - Bits 24 to 1 of a write frame are the write data.
// - Write answer carries the old value latched after bit 25.
// - Write commits at frame end only if address, length, parity are good.
// - Test registers ignore writes but answer; unmapped writes answer zeros.
// - Flags are derived from event status; reading it clears both.
// - Event status read clears at the chip select rising edge.
// - Reset flag set after power-on, hardware or software reset.
// - Only exactly 32 bits accepted; any other nonzero count sets length error, attention low.
// - Odd parity on input; even count sets parity error, attention low.
// - Switch-change flag mirrors the switch event bit.
// - Supply flag is OR of both supply comparison events.
// - Thermal flag is OR of thermal warning and shutdown events.
// - Other flag ORs six remaining fault and completion events.
// - Sample on falling serial clock, drive on rising, MSB first.
// - Chip select fall enables output and snapshots status; rise disables.
// - Attention returns high at chip select rise after status read.
// - Output high at select fall; each rising edge presents next bit.
`timescale 1ns/1ps
module spi_frame_target #(
    parameter logic [23:0] DEVICE_ID = spi_flags_pkg::DEVICE_ID_DEFAULT
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic I_SCLK,
    input wire logic I_CS_N,
    input wire logic I_SI,
    output logic O_SO,
    output logic O_SO_OE,
    output logic O_INT_N,
    input wire logic [spi_flags_pkg::STAT_W-1:0] I_EVENT_SET,
    input wire logic I_SOFT_RST,
    output logic [spi_flags_pkg::CFG_COUNT*spi_flags_pkg::DATA_W-1:0] O_CFG_DATA,
    output logic [spi_flags_pkg::STAT_W-1:0] O_EVENT_STAT
);
    localparam int DW = spi_flags_pkg::DATA_W;
    localparam int AW = spi_flags_pkg::ADDR_W;
    localparam int CW = spi_flags_pkg::CNT_W;
    localparam int SW = spi_flags_pkg::STAT_W;

    logic [DW-1:0] cfg_reg [spi_flags_pkg::CFG_COUNT];
    logic [SW-1:0] event_stat_reg;
    logic [SW-1:0] snap_reg;
    logic int_n_reg;

    // ==========================================================
    // Address decoding
    function automatic logic is_cfg(input logic [AW-1:0] a);
        is_cfg = (a >= spi_flags_pkg::ADDR_CFG_FIRST) && (a <= spi_flags_pkg::ADDR_CFG_LAST);
    endfunction : is_cfg

    function automatic logic is_test(input logic [AW-1:0] a);
        is_test = (a >= spi_flags_pkg::ADDR_TEST_FIRST) && (a <= spi_flags_pkg::ADDR_TEST_LAST);
    endfunction : is_test

    // Status flags in output order
    function automatic logic [spi_flags_pkg::FLAG_W-1:0] flags_of(input logic [SW-1:0] s);
        flags_of = {s[spi_flags_pkg::EV_RESET],
                    s[spi_flags_pkg::EV_LENGTH],
                    s[spi_flags_pkg::EV_PARITY],
                    s[spi_flags_pkg::EV_SWITCH],
                    s[spi_flags_pkg::EV_SUPPLY_A] | s[spi_flags_pkg::EV_SUPPLY_B],
                    s[spi_flags_pkg::EV_THERM_WARN] | s[spi_flags_pkg::EV_THERM_SD],
                    s[spi_flags_pkg::EV_OVER_V] | s[spi_flags_pkg::EV_UNDER_V]
                    | s[spi_flags_pkg::EV_CHECKSUM] | s[spi_flags_pkg::EV_WETTING]
                    | s[spi_flags_pkg::EV_CONVERTER] | s[spi_flags_pkg::EV_INTEGRITY]};
    endfunction : flags_of

    // ==========================================================
    // Register read mux, used from the link side
    // Config registers only change while chip select is high, so the link may
    // read them mid-frame; a frame started during the commit window may see a
    // half-written value.
    // Flag bits read the snapshot directly; it is only quiet once the system
    // side has seen select low, hence the host's setup wait after select falls.
    logic [AW-1:0] link_addr;
    logic [DW-1:0] link_read_data;

    always_comb begin
        link_read_data = '0;
        if (link_addr == spi_flags_pkg::ADDR_DEVICE_ID) begin
            link_read_data = DEVICE_ID;
        end else if (link_addr == spi_flags_pkg::ADDR_EVENT_STAT) begin
            link_read_data = DW'(snap_reg);
        end else if (is_cfg(link_addr)) begin
            link_read_data = cfg_reg[5'(link_addr - spi_flags_pkg::ADDR_CFG_FIRST)];
        end else if (is_test(link_addr)) begin
            link_read_data = spi_flags_pkg::TEST_DEFAULT;
        end
    end

    // ==========================================================
    // Link side, receive on falling serial clock
    // Cleared while chip select is high; the counter saturates so overlong
    // frames never wrap back to a legal length.
    logic [31:0] rx_shift_reg;
    logic [CW-1:0] rx_cnt_reg;
    logic [DW-1:0] old_data_reg;

    assign link_addr = {rx_shift_reg[4:0], I_SI};

    always_ff @(negedge I_SCLK or posedge I_CS_N or posedge I_RST) begin
        if (I_RST || I_CS_N) begin
            rx_shift_reg <= 32'h00000000;
            rx_cnt_reg <= '0;
        end else begin
            rx_shift_reg <= {rx_shift_reg[30:0], I_SI};
            if (rx_cnt_reg != spi_flags_pkg::CNT_MAX) begin
                rx_cnt_reg <= rx_cnt_reg + 6'h01;
            end
        end
    end

    always_ff @(negedge I_SCLK or posedge I_CS_N or posedge I_RST) begin
        if (I_RST || I_CS_N) begin
            old_data_reg <= '0;
        end else if (rx_cnt_reg == spi_flags_pkg::CNT_ADDR_DONE) begin
            old_data_reg <= link_read_data;
        end
    end

    // ==========================================================
    // Link side, transmit on rising serial clock
    logic [CW-1:0] tx_cnt_reg;
    logic so_reg;
    logic [31:0] resp_word;
    logic [spi_flags_pkg::FLAG_W-1:0] resp_flags;

    assign resp_flags = flags_of(snap_reg);
    assign resp_word = {resp_flags, old_data_reg, ~^{resp_flags, old_data_reg}};

    always_ff @(posedge I_SCLK or posedge I_CS_N or posedge I_RST) begin
        if (I_RST || I_CS_N) begin
            tx_cnt_reg <= '0;
            so_reg <= 1'b1;
        end else begin
            if (tx_cnt_reg < spi_flags_pkg::CNT_FULL) begin
                so_reg <= resp_word[5'(~tx_cnt_reg[4:0])];
                tx_cnt_reg <= tx_cnt_reg + 6'h01;
            end else begin
                so_reg <= 1'b0;
            end
        end
    end

    assign O_SO = so_reg;
    assign O_SO_OE = ~I_CS_N;

    // Bits past the 32nd read as zero
    a_tail_zero: assert property (@(negedge I_SCLK) disable iff (I_RST || I_CS_N)
        (tx_cnt_reg == spi_flags_pkg::CNT_FULL && rx_cnt_reg >= spi_flags_pkg::CNT_FULL)
        |-> !so_reg)
        else $error("serial output not low past bit 32");

    // ==========================================================
    // Frame capture on chip select rise
    // Held until the next rise, so the system side reads it at leisure.
    logic [31:0] frame_word_reg;
    logic [CW-1:0] frame_cnt_reg;

    always_ff @(posedge I_CS_N or posedge I_RST) begin
        if (I_RST) begin
            frame_word_reg <= 32'h00000000;
            frame_cnt_reg <= '0;
        end else begin
            frame_word_reg <= rx_shift_reg;
            frame_cnt_reg <= rx_cnt_reg;
        end
    end

    // ==========================================================
    // Chip select into the system domain
    logic cs_level;
    logic cs_prev_reg;
    logic frame_end;

    pin_sync3 #(
        .RESET_VAL(1'b1)
    ) u_cs_sync (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_async(I_CS_N),
        .o_level(cs_level)
    );

    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            cs_prev_reg <= 1'b1;
        end else begin
            cs_prev_reg <= cs_level;
        end
    end

    assign frame_end = cs_level & ~cs_prev_reg;

    // ==========================================================
    // Frame checks
    logic frame_seen;
    logic len_bad;
    logic par_bad;
    logic frame_ok;
    logic is_write;
    logic [AW-1:0] frame_addr;
    logic [DW-1:0] frame_data;
    logic write_go;
    logic stat_read;

    assign frame_seen = frame_cnt_reg != '0;
    assign len_bad = frame_seen && (frame_cnt_reg != spi_flags_pkg::CNT_FULL);
    assign par_bad = !len_bad && frame_seen && !(^frame_word_reg);
    assign frame_ok = frame_seen && !len_bad && !par_bad;
    assign is_write = frame_word_reg[spi_flags_pkg::RW_POS];
    assign frame_addr = frame_word_reg[spi_flags_pkg::ADDR_MSB:spi_flags_pkg::ADDR_LSB];
    assign frame_data = frame_word_reg[spi_flags_pkg::DATA_MSB:spi_flags_pkg::DATA_LSB];
    assign write_go = frame_end && frame_ok && is_write && is_cfg(frame_addr);
    // Read data bits play no part in a read frame
    assign stat_read = frame_end && frame_ok && !is_write
                       && (frame_addr == spi_flags_pkg::ADDR_EVENT_STAT);

    // ==========================================================
    // Config registers
    genvar gi;
    generate
        for (gi = 0; gi < spi_flags_pkg::CFG_COUNT; gi++) begin : g_cfg
            always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
                if (I_RST) begin
                    cfg_reg[gi] <= spi_flags_pkg::CFG_RESET;
                end else if (write_go
                             && (5'(frame_addr - spi_flags_pkg::ADDR_CFG_FIRST) == 5'(gi))) begin
                    cfg_reg[gi] <= frame_data;
                end
            end
            assign O_CFG_DATA[gi*DW +: DW] = cfg_reg[gi];
        end
    endgenerate

    // ==========================================================
    // Event status
    // Only bits shown in the snapshot are cleared, so an event landing
    // during the frame survives; a fresh set always beats the clear.
    logic [SW-1:0] ev_set;
    logic [SW-1:0] event_stat_next;

    always_comb begin
        ev_set = I_EVENT_SET;
        ev_set[spi_flags_pkg::EV_RESET] = I_EVENT_SET[spi_flags_pkg::EV_RESET] | I_SOFT_RST;
        ev_set[spi_flags_pkg::EV_LENGTH] = frame_end && len_bad;
        ev_set[spi_flags_pkg::EV_PARITY] = frame_end && par_bad;
        event_stat_next = event_stat_reg;
        if (stat_read) begin
            event_stat_next = event_stat_reg & ~snap_reg;
        end
        event_stat_next = event_stat_next | ev_set;
    end

    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            event_stat_reg <= spi_flags_pkg::EVENT_STAT_RESET;
        end else begin
            event_stat_reg <= event_stat_next;
        end
    end

    // Snapshot follows status while deselected, frozen once select is seen low
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            snap_reg <= spi_flags_pkg::EVENT_STAT_RESET;
        end else if (cs_level) begin
            snap_reg <= event_stat_next;
        end
    end

    // Attention follows pending events; released once a read clears them
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            int_n_reg <= 1'b0;
        end else begin
            int_n_reg <= ~|event_stat_next;
        end
    end

    assign O_INT_N = int_n_reg;
    assign O_EVENT_STAT = event_stat_reg;

    // ==========================================================
    // Checks
    a_len_error_set: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (frame_end && frame_seen && frame_cnt_reg != 6'h20)
        |=> event_stat_reg[1] && !O_INT_N)
        else $error("length error not flagged");

    a_parity_error_set: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (frame_end && frame_cnt_reg == 6'h20 && !(^frame_word_reg))
        |=> event_stat_reg[2] && !O_INT_N)
        else $error("parity error not flagged");

    a_write_commit: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (frame_end && frame_ok && is_write && frame_addr == 6'h1a)
        |=> cfg_reg[0] == $past(frame_data))
        else $error("valid write not committed");

    a_bad_write_hold: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (frame_end && !write_go) |=> $stable(O_CFG_DATA))
        else $error("config changed without valid write");

    a_no_frame_quiet: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (frame_end && frame_cnt_reg == 6'h00 && I_EVENT_SET == '0 && !I_SOFT_RST
         && !stat_read) |=> $stable(event_stat_reg))
        else $error("empty frame changed status");

    a_stat_clear: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (stat_read && I_EVENT_SET == '0 && !I_SOFT_RST)
        |=> event_stat_reg == ($past(event_stat_reg) & ~$past(snap_reg)))
        else $error("status read did not clear");

    a_soft_reset_flag: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        I_SOFT_RST |=> event_stat_reg[0] ##1 (event_stat_reg[0] || $past(stat_read)))
        else $error("reset flag missing after soft reset");

    a_snap_frozen: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (!cs_level && !cs_prev_reg) |-> $stable(snap_reg))
        else $error("snapshot moved during frame");

    a_int_release: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (event_stat_reg == '0) [*2] |-> O_INT_N)
        else $error("attention held with no events");

    a_int_low_pending: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (event_stat_reg != '0) |-> !O_INT_N)
        else $error("attention high with events pending");
endmodule : spi_frame_target

// ---- spi_host_model.sv ----
// Host controller model that frames 32-bit transfers towards the serial target.
// Assumes the caller leaves it idle between frames; serial clock rests low.
`timescale 1ns/1ps
module spi_host_model (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_si,
    input wire logic i_so,
    input wire logic i_so_oe
);
    // =====================================
    // Link timing: 30 ns serial clock, only inside frames
    localparam int HALF_NS = 15;
    localparam int SETUP_NS = 240;
    localparam int GAP_NS = 400;

    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end

    // Caller builds bit 31 as R/W, then address, data and odd parity
    task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx,
                        output logic [1:0] idle);
        int k;
        rx = 32'h00000000;
        o_cs_n = 1'b0;
        // Lets the target freeze its flag snapshot before bit 31 leaves
        #(SETUP_NS);
        idle = {i_so_oe, i_so};
        for (k = 1; k <= nbits; k++) begin
            o_sclk = 1'b1;
            o_si = (k <= 32) ? tx[32-k] : 1'b0;
            #(HALF_NS);
            o_sclk = 1'b0;
            rx = {rx[30:0], i_so};
            #(HALF_NS);
        end
        o_cs_n = 1'b1;
        // Released line must not keep the last bit
        o_si = ~o_si;
        // Sys domain needs several clocks to commit after the frame
        #(GAP_NS);
    endtask : xfer
endmodule : spi_host_model

// ---- testbench.sv ----
// Self-checking bench for the serial target: frames, register map, errors, events.
// Assumes the host model drives the link pins and the bench drives sys-side inputs.
`timescale 1ns/1ps
module testbench;
    logic sys_clk;
    logic rst;
    logic soft_rst;
    logic [spi_flags_pkg::STAT_W-1:0] event_set;
    wire sclk;
    wire cs_n;
    wire si;
    wire so;
    wire so_oe;
    wire int_n;
    wire [spi_flags_pkg::CFG_COUNT*spi_flags_pkg::DATA_W-1:0] cfg;
    wire [spi_flags_pkg::STAT_W-1:0] stat;
    int err_count;
    int samples_checked;

    spi_frame_target spi_frame_target_inst (.I_SYS_CLK(sys_clk), .I_RST(rst), .I_SCLK(sclk),
        .I_CS_N(cs_n), .I_SI(si), .O_SO(so), .O_SO_OE(so_oe), .O_INT_N(int_n),
        .I_EVENT_SET(event_set), .I_SOFT_RST(soft_rst), .O_CFG_DATA(cfg),
        .O_EVENT_STAT(stat));
    spi_host_model spi_host_model_inst (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si),
        .i_so(so), .i_so_oe(so_oe));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // =====================================
    // Helpers
    function automatic logic [31:0] mk(logic rw, logic [5:0] a, logic [23:0] d);
        return {rw, a, d, ~^{rw, a, d}};
    endfunction : mk

    function automatic logic [31:0] resp(logic [6:0] f, logic [23:0] d);
        return {f, d, ~^{f, d}};
    endfunction : resp

    function automatic logic [6:0] flags_of(logic [13:0] s);
        return {s[0], s[1], s[2], s[3], s[9] | s[10], s[4] | s[5],
                s[6] | s[7] | s[8] | s[11] | s[12] | s[13]};
    endfunction : flags_of

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic xf(input logic rw, input logic [5:0] a, input logic [23:0] d,
                      output logic [31:0] rx);
        logic [1:0] idle;
        spi_host_model_inst.xfer(mk(rw, a, d), 32, rx, idle);
    endtask : xf

    task automatic stop_test();
        $display("Counts: %0d checked, %0d mismatches", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    // =====================================
    // Scenarios
    task automatic t_reset_status();
        logic [31:0] rx;
        logic [1:0] idle;
        spi_host_model_inst.xfer(mk(1'b0, 6'h02, 24'h5a5a5a), 32, rx, idle);
        check("idle_oe_so", 32'h3, {30'h0, idle});
        check("status_read", resp(7'h40, 24'h000001), rx);
        check("stat_cleared", 32'h0, {18'h0, stat});
        check("int_released", 32'h1, {31'h0, int_n});
        check("oe_off", 32'h0, {31'h0, so_oe});
        $display("t_reset_status finished");
    endtask : t_reset_status

    task automatic t_cfg_write();
        logic [31:0] rx;
        xf(1'b1, 6'h1a, 24'ha5c3e1, rx);
        check("wr_first_old", resp(7'h0, 24'h0), rx);
        xf(1'b1, 6'h1a, 24'h3c5a96, rx);
        check("wr_second_old", resp(7'h0, 24'ha5c3e1), rx);
        check("cfg_first", 32'h3c5a96, {8'h0, cfg[23:0]});
        xf(1'b1, 6'h32, 24'hffffff, rx);
        check("cfg_last", 32'hffffff, {8'h0, cfg[599:576]});
        xf(1'b0, 6'h1a, 24'h000000, rx);
        check("rd_cfg", resp(7'h0, 24'h3c5a96), rx);
        $display("t_cfg_write finished");
    endtask : t_cfg_write

    task automatic t_reg_map();
        logic [31:0] rx;
        xf(1'b1, 6'h01, 24'h123456, rx);
        check("wr_id_old", resp(7'h0, spi_flags_pkg::DEVICE_ID_DEFAULT), rx);
        xf(1'b0, 6'h01, 24'h000000, rx);
        check("rd_id", resp(7'h0, spi_flags_pkg::DEVICE_ID_DEFAULT), rx);
        xf(1'b1, 6'h3a, 24'h777777, rx);
        check("wr_test", resp(7'h0, spi_flags_pkg::TEST_DEFAULT), rx);
        xf(1'b0, 6'h3f, 24'h000000, rx);
        check("rd_test", resp(7'h0, spi_flags_pkg::TEST_DEFAULT), rx);
        xf(1'b1, 6'h05, 24'h111111, rx);
        check("wr_unmapped", resp(7'h0, 24'h0), rx);
        xf(1'b0, 6'h19, 24'hffffff, rx);
        check("rd_unmapped", resp(7'h0, 24'h0), rx);
        check("cfg_kept", 32'h1, {31'h0, cfg === {24'hffffff, 552'h0, 24'h3c5a96}});
        $display("t_reg_map finished");
    endtask : t_reg_map

    task automatic t_bad_frames();
        logic [31:0] rx;
        logic [1:0] idle;
        spi_host_model_inst.xfer(32'h00000000, 0, rx, idle);
        check("no_clock_frame", 32'h0, {18'h0, stat});
        spi_host_model_inst.xfer(mk(1'b1, 6'h1b, 24'h123456) ^ 32'h1, 32, rx, idle);
        check("parity_bit", 32'h4, {18'h0, stat});
        check("parity_int", 32'h0, {31'h0, int_n});
        spi_host_model_inst.xfer(mk(1'b1, 6'h1b, 24'h654321), 31, rx, idle);
        check("length_bit", 32'h6, {18'h0, stat});
        check("cfg_no_commit", 32'h1, {31'h0, cfg === {24'hffffff, 552'h0, 24'h3c5a96}});
        xf(1'b0, 6'h02, 24'h000000, rx);
        check("err_flags", resp(7'h30, 24'h000006), rx);
        check("err_cleared", 32'h0, {18'h0, stat});
        check("err_int_high", 32'h1, {31'h0, int_n});
        spi_host_model_inst.xfer(mk(1'b1, 6'h1b, 24'h0f0f0f), 33, rx, idle);
        check("long_frame_tail", resp(7'h0, 24'h0) << 1, rx);
        check("long_length_bit", 32'h2, {18'h0, stat});
        xf(1'b0, 6'h02, 24'h000000, rx);
        check("long_flags", resp(7'h20, 24'h000002), rx);
        check("long_cleared", 32'h0, {18'h0, stat});
        $display("t_bad_frames finished");
    endtask : t_bad_frames

    task automatic t_events();
        int bits[12] = '{0, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13};
        logic [13:0] ev;
        logic [31:0] rx;
        foreach (bits[i]) begin
            ev = 14'h0001 << bits[i];
            @(negedge sys_clk);
            if (bits[i] == 0) begin
                soft_rst = 1'b1;
            end else begin
                event_set = ev;
            end
            @(negedge sys_clk);
            soft_rst = 1'b0;
            event_set = 14'h0000;
            @(negedge sys_clk);
            check("event_bit", {18'h0, ev}, {18'h0, stat});
            check("event_int", 32'h0, {31'h0, int_n});
            xf(1'b0, 6'h02, 24'h000000, rx);
            check("event_flags", resp(flags_of(ev), {10'h0, ev}), rx);
            check("event_clear", 32'h0, {18'h0, stat});
        end
        $display("t_events finished");
    endtask : t_events

    // =====================================
    // Sequence and watchdog
    initial begin
        err_count = 0;
        samples_checked = 0;
        rst = 1'b1;
        soft_rst = 1'b0;
        event_set = 14'h0000;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        repeat (6) @(negedge sys_clk);
        t_reset_status();
        t_cfg_write();
        t_reg_map();
        t_bad_frames();
        t_events();
        stop_test();
    end

    initial begin
        // About 29 frames of 1.6 us each; generous margin
        #200000;
        err_count++;
        $display("[FAIL] watchdog expected finish seen hang");
        stop_test();
    end
endmodule : testbench
